// file: mac_flags_params.svh
// constants for the accumulator compare and shift flag block
`ifndef MAC_FLAGS_PARAMS_SVH
`define MAC_FLAGS_PARAMS_SVH
`define ACC_WIDTH      40
`define STATUS_WIDTH   16
`define STATUS_RESET   16'h0000
`define FLAG_E_POS     5
`define FLAG_SV_POS    6
`define FLAG_C_POS     10
`define FLAG_Z_POS     9
`define FLAG_N_POS     8
`define SHIFT_WIDTH    5
`endif

// file: mac_flags_pkg.sv
// types for the accumulator compare and shift flag block
package mac_flags_pkg;
  typedef enum logic [1:0] {
    OP_NONE  = 2'b00,
    OP_CMP   = 2'b01,
    OP_LSHR  = 2'b11,
    OP_ASHR  = 2'b10
  } op_t;
endpackage

// file: mac_compare_shift_flags.sv
// accumulator compare and right shift with status flags, as built
`timescale 1ns/1ps
`include "mac_flags_params.svh"

module mac_compare_shift_flags #(
  parameter int ACC_W = `ACC_WIDTH
) (
  input  wire logic                     core_clk,      // cpu clock
  input  wire logic                     srst,          // sync reset, high
  input  wire logic                     op_valid,      // one-cycle issue
  input  wire mac_flags_pkg::op_t       op_code,       // operation
  input  wire logic [ACC_W-1:0]         operand,       // compare operand
  input  wire logic [`SHIFT_WIDTH-1:0]  shift_count,   // shift amount
  input  wire logic                     acc_load,      // load accumulator
  input  wire logic [ACC_W-1:0]         acc_load_data, // value to load
  input  wire logic                     status_load,   // write status word
  input  wire logic [`STATUS_WIDTH-1:0] status_data,   // status word value
  input  wire logic                     saturation_mode_bit, // control bit
  output logic [ACC_W-1:0]              accumulator,   // 40-bit accumulator
  output logic [`STATUS_WIDTH-1:0]      unit_status_word, // flags
  output logic                          op_done        // pulse after op
);

  // extension in use: the top nine bits (extension byte and the high bit
  // of the high word) are not all copies of one sign
  function automatic logic ext_used(input logic [ACC_W-1:0] v);
    ext_used = !((&v[ACC_W-1:ACC_W-9]) || !(|v[ACC_W-1:ACC_W-9]));
  endfunction

  // both right shifts share this decode; compare and idle keep the data
  function automatic logic is_shift(input mac_flags_pkg::op_t op);
    is_shift = (op == mac_flags_pkg::OP_LSHR) ||
               (op == mac_flags_pkg::OP_ASHR);
  endfunction

  // carry after the reversed compare: set when the accumulator is at
  // least the operand, so a borrow out of operand minus accumulator or a
  // zero difference; an equal pair must read as greater or equal
  function automatic logic cmp_carry(input logic [ACC_W:0] d);
    cmp_carry = d[ACC_W] || (d[ACC_W-1:0] == '0);
  endfunction

  logic [ACC_W:0]   diff;
  logic [ACC_W-1:0] shifted;

  // reversed subtraction: the operand minus the accumulator
  always_comb begin
    diff = {1'b0, operand} - {1'b0, accumulator};
  end

  // full-width shift; bit 32 falls into bit 31 naturally
  always_comb begin
    if (op_code == mac_flags_pkg::OP_ASHR) begin
      shifted = $signed(accumulator) >>> shift_count;
    end else begin
      shifted = accumulator >> shift_count;
    end
  end

  // accumulator: compare leaves it alone, shifts never saturate
  always_ff @(posedge core_clk) begin
    if (srst) begin
      accumulator <= '0;
    end else if (acc_load) begin
      accumulator <= acc_load_data;
    end else if (op_valid && is_shift(op_code)) begin
      // the shift ignores saturation, so the result goes in unclipped
      accumulator <= shifted;
    end
  end

  // status word update
  always_ff @(posedge core_clk) begin
    if (srst) begin
      unit_status_word <= `STATUS_RESET;
    end else if (status_load) begin
      unit_status_word <= status_data;
    end else if (op_valid) begin
      case (op_code)
        mac_flags_pkg::OP_CMP: begin
          // reversed direction: a set carry means accumulator >= operand
          unit_status_word[`FLAG_N_POS] <= diff[ACC_W-1];
          unit_status_word[`FLAG_C_POS] <= cmp_carry(diff);
        end
        mac_flags_pkg::OP_LSHR, mac_flags_pkg::OP_ASHR: begin
          // the silicon fault: saturation mode forces the flag low
          if (saturation_mode_bit) begin
            unit_status_word[`FLAG_E_POS] <= 1'b0;
          end else begin
            unit_status_word[`FLAG_E_POS] <= ext_used(shifted);
          end
        end
        default: begin
          unit_status_word <= unit_status_word;
        end
      endcase
    end
  end

  // completion pulse one cycle after issue
  always_ff @(posedge core_clk) begin
    if (srst) begin
      op_done <= 1'b0;
    end else begin
      op_done <= op_valid && op_code != mac_flags_pkg::OP_NONE;
    end
  end

  // a compare reads the accumulator but never writes it
  cmp_keeps_acc_a: assert property (
    @(posedge core_clk) disable iff (srst)
    op_valid && op_code == mac_flags_pkg::OP_CMP && !acc_load
      |=> $stable(accumulator))
    else $error("compare changed accumulator");

  // the zero flag is outside what the compare updates
  cmp_zero_kept_a: assert property (
    @(posedge core_clk) disable iff (srst)
    op_valid && op_code == mac_flags_pkg::OP_CMP && !status_load
      |=> $stable(unit_status_word[`FLAG_Z_POS]))
    else $error("compare changed zero flag");

  // software tests the carry for accumulator >= operand
  cmp_carry_a: assert property (
    @(posedge core_clk) disable iff (srst)
    op_valid && op_code == mac_flags_pkg::OP_CMP && !status_load
      |=> unit_status_word[`FLAG_C_POS] ==
          ($past(accumulator) >= $past(operand)))
    else $error("carry flag wrong after compare");

  // with one sign on both sides the difference cannot overflow, so the
  // negative flag must mean operand below accumulator
  cmp_neg_a: assert property (
    @(posedge core_clk) disable iff (srst)
    op_valid && op_code == mac_flags_pkg::OP_CMP && !status_load &&
      operand[ACC_W-1] == accumulator[ACC_W-1]
      |=> unit_status_word[`FLAG_N_POS] ==
          ($past(operand) < $past(accumulator)))
    else $error("negative flag wrong after compare");

  // as built, saturation mode leaves the extension flag clear
  shift_sat_e_a: assert property (
    @(posedge core_clk) disable iff (srst)
    op_valid && is_shift(op_code) && saturation_mode_bit && !status_load
      |=> !unit_status_word[`FLAG_E_POS])
    else $error("extension flag not as built");

  // the low extension bit lands in the top bit of the high word
  shift_lsb_a: assert property (
    @(posedge core_clk) disable iff (srst)
    op_valid && is_shift(op_code) && !acc_load && shift_count == 5'h01
      |=> accumulator[ACC_W-9] == $past(accumulator[ACC_W-8]))
    else $error("extension bit 0 not moved");

  // saturation off: the flag follows the top nine bits (extension byte and bit 31) of the result
  shift_nosat_e_a: assert property (
    @(posedge core_clk) disable iff (srst)
    op_valid && is_shift(op_code) && !saturation_mode_bit &&
      !status_load && !acc_load
      |=> unit_status_word[`FLAG_E_POS] == ext_used(accumulator))
    else $error("extension flag wrong");

  // a shift by eight moves the whole 40 bits; nothing is clipped
  shift_width_a: assert property (
    @(posedge core_clk) disable iff (srst)
    op_valid && is_shift(op_code) && !acc_load && shift_count == 5'h08
      |=> accumulator[ACC_W-9:0] == $past(accumulator[ACC_W-1:8]))
    else $error("shift lost bits");

  // a logical shift fills from the top with zeros
  lshr_top_zero_a: assert property (
    @(posedge core_clk) disable iff (srst)
    op_valid && op_code == mac_flags_pkg::OP_LSHR && !acc_load &&
      shift_count != 5'h00
      |=> !accumulator[ACC_W-1])
    else $error("logical shift kept top bit");

  // an arithmetic shift keeps the sign of the 40-bit value
  ashr_sign_a: assert property (
    @(posedge core_clk) disable iff (srst)
    op_valid && op_code == mac_flags_pkg::OP_ASHR && !acc_load
      |=> accumulator[ACC_W-1] == $past(accumulator[ACC_W-1]))
    else $error("arithmetic shift lost sign");

  // shifts only touch the extension flag; compare flags stay put
  shift_keeps_cnz_a: assert property (
    @(posedge core_clk) disable iff (srst)
    op_valid && is_shift(op_code) && !status_load
      |=> $stable(unit_status_word[`FLAG_C_POS:`FLAG_N_POS]))
    else $error("shift changed compare flags");

  // the idle code and an idle cycle change nothing
  idle_keeps_a: assert property (
    @(posedge core_clk) disable iff (srst)
    (!op_valid || op_code == mac_flags_pkg::OP_NONE) && !acc_load &&
      !status_load
      |=> $stable(accumulator) && $stable(unit_status_word))
    else $error("idle cycle changed state");

  // every real operation reports completion on the next cycle
  done_pulse_a: assert property (
    @(posedge core_clk) disable iff (srst)
    op_valid && op_code != mac_flags_pkg::OP_NONE
      |=> op_done)
    else $error("completion missing");

  // no completion without an operation in the cycle before
  done_quiet_a: assert property (
    @(posedge core_clk) disable iff (srst)
    !op_valid || op_code == mac_flags_pkg::OP_NONE
      |=> !op_done)
    else $error("completion without operation");

  // a load beats any operation issued in the same cycle
  acc_load_a: assert property (
    @(posedge core_clk) disable iff (srst)
    acc_load
      |=> accumulator == $past(acc_load_data))
    else $error("accumulator load lost");

  // a status write beats the flag update of the same cycle
  status_load_a: assert property (
    @(posedge core_clk) disable iff (srst)
    status_load
      |=> unit_status_word == $past(status_data))
    else $error("status write lost");

  // reset clears every output on the following edge
  rst_clear_a: assert property (
    @(posedge core_clk)
    srst
      |=> accumulator == '0 && unit_status_word == `STATUS_RESET &&
          !op_done)
    else $error("reset left outputs set");

endmodule

// file: cpu_model.sv
// cpu side model that issues loads and operations to the block
`timescale 1ns/1ps
module cpu_model (
  input  wire logic          core_clk,      // cpu clock
  output logic               op_valid,      // issue strobe
  output logic               acc_load,      // accumulator load strobe
  output logic               status_load,   // status load strobe
  output mac_flags_pkg::op_t op_code,       // operation
  output logic [39:0]        operand,       // compare operand
  output logic [39:0]        acc_load_data, // accumulator load value
  output logic [4:0]         shift_count,   // shift amount
  output logic [15:0]        status_data    // status value
);
  initial begin
    {op_valid, acc_load, status_load} = 3'h0;
    op_code = mac_flags_pkg::OP_NONE;
    {operand, acc_load_data, shift_count, status_data} = '0;
  end
  // strobes change on falling edges only, so each is high one whole cycle
  task automatic go(input logic [2:0] s, input mac_flags_pkg::op_t op,
    input logic [39:0] v, a, input logic [4:0] n, input logic [15:0] d);
    @(negedge core_clk);
    {op_valid, acc_load, status_load} = s;
    op_code = op;
    {operand, acc_load_data, shift_count, status_data} = {v, a, n, d};
    @(negedge core_clk);
    {op_valid, acc_load, status_load} = 3'h0;
  endtask
endmodule

// file: mac_compare_shift_flags_test.sv
// self-checking bench for the compare and shift flag block
`timescale 1ns/1ps
`include "mac_flags_params.svh"
module mac_compare_shift_flags_test;
  logic core_clk = 1'b0, srst = 1'b1, sat = 1'b0, op_valid, op_done;
  logic acc_load, status_load;
  mac_flags_pkg::op_t op_code, op;
  logic [39:0] operand, acc_load_data, accumulator, a, v;
  logic [4:0]  shift_count;
  logic [15:0] status_data, unit_status_word;
  logic [55:0] notes[$];
  logic [39:0] exp_acc;
  logic [15:0] exp_sw;
  int error_cnt = 0, n_compared = 0, seed = 32'hc2d8;
  always #12.5 core_clk = ~core_clk;
  cpu_model u_cpu (.core_clk, .op_valid, .acc_load, .status_load, .op_code,
    .operand, .acc_load_data, .shift_count, .status_data);
  mac_compare_shift_flags u_dut (.core_clk, .srst, .op_valid, .op_code,
    .operand, .shift_count, .acc_load, .acc_load_data, .status_load,
    .status_data, .saturation_mode_bit(sat), .accumulator,
    .unit_status_word, .op_done);
  task automatic check(input string w, input logic [55:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", w, exp, seen);
    end
  endtask
  // load a fresh accumulator and status, then issue one operation
  task automatic step(input logic [39:0] a, input logic [15:0] d,
    input mac_flags_pkg::op_t op, input logic [39:0] v,
    input logic [4:0] n, input logic s);
    logic [39:0] acc;
    logic [15:0] sw;
    logic [40:0] diff;
    logic        ext;
    u_cpu.go(3'h3, op, v, a, n, d);
    sat = s;
    acc = a;
    sw = d;
    diff = {1'b0, v} - {1'b0, a};
    ext = 1'b0;
    if (op == mac_flags_pkg::OP_CMP) begin
      sw[`FLAG_N_POS] = diff[39];
      sw[`FLAG_C_POS] = a >= v;
    end else if (op != mac_flags_pkg::OP_NONE) begin
      if (op == mac_flags_pkg::OP_ASHR) acc = $signed(a) >>> n;
      else acc = a >> n;
      ext = acc[39:31] != 9'h000 && acc[39:31] != 9'h1ff;
      // saturation on reads as a stuck-clear extension flag
      sw[`FLAG_E_POS] = !s && ext;
    end
    if (op != mac_flags_pkg::OP_NONE) notes.push_back({acc, sw});
    u_cpu.go(3'h4, op, v, a, n, d);
    // the idle code must leave everything alone and raise no completion
    if (op == mac_flags_pkg::OP_NONE) begin
      check("idle state", {accumulator, unit_status_word}, {acc, sw});
      check("idle done", 56'(op_done), 56'h0);
    end
  endtask
  // each op_done pairs with the oldest note
  always @(negedge core_clk) if (op_done === 1'b1) begin
    if (notes.size() == 0) check("stray op_done", 56'h1, 56'h0);
    else begin
      {exp_acc, exp_sw} = notes.pop_front();
      check("accumulator", 56'(accumulator), 56'(exp_acc));
      check("acc bit 31", 56'(accumulator[31]), 56'(exp_acc[31]));
      check("status", 56'(unit_status_word), 56'(exp_sw));
      check("c flag", 56'(unit_status_word[10]), 56'(exp_sw[10]));
      check("e flag", 56'(unit_status_word[5]), 56'(exp_sw[5]));
    end
  end
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge core_clk);
    srst = 1'b0;
    step(40'h7_0000, 16'h0, mac_flags_pkg::OP_CMP, 40'h6_0000, 5'h0, 1'b0);
    step(40'h5, 16'h0200, mac_flags_pkg::OP_CMP, 40'h5, 5'h0, 1'b0);
    step(40'h7f_5555_5555, 16'h0, mac_flags_pkg::OP_LSHR, 40'h0, 5'h1, 1'b1);
    step(40'h7f_5555_5555, 16'h0, mac_flags_pkg::OP_LSHR, 40'h0, 5'h1, 1'b0);
    step(40'h80_1234_5678, 16'h0, mac_flags_pkg::OP_ASHR, 40'h0, 5'h8, 1'b0);
    step(40'h9_789a, 16'h0400, mac_flags_pkg::OP_NONE, 40'h0, 5'h3, 1'b0);
    $display("test fixed cases done");
    // random mix of all four codes; compare values kept positive
    for (int i = 0; i < 60; i++) begin
      op = mac_flags_pkg::op_t'(i % 4);
      a = 40'({$random(seed), $random(seed)});
      v = 40'({$random(seed), $random(seed)}) & 40'h7f_ffff_ffff;
      if (op == mac_flags_pkg::OP_CMP) a[39] = 1'b0;
      step(a, 16'($random(seed)), op, v, 5'($random(seed)),
        1'($random(seed)));
    end
    for (int k = 0; k < 10 && notes.size() != 0; k++) @(negedge core_clk);
    if (notes.size() != 0) check("missing op_done", 56'h1, 56'h0);
    $display("test random mix done");
    close_out();
  end
endmodule
